/* hdl/aam_defines.vh */
// constants for the arp/icmp access control entry matcher
`ifndef AAM_DEFINES_VH
`define AAM_DEFINES_VH

// ==========================================================
// register byte offsets (apb, one aligned word each)
`define AAM_OFF_CTRL        8'h00
`define AAM_OFF_SENDER_IP   8'h04
`define AAM_OFF_SENDER_MASK 8'h08
`define AAM_OFF_TARGET_IP   8'h0c
`define AAM_OFF_TARGET_MASK 8'h10
`define AAM_OFF_ICMP        8'h14
`define AAM_OFF_STATUS      8'h18
`define AAM_OFF_EVAL_CNT    8'h1c
`define AAM_OFF_HIT_CNT     8'h20

// ==========================================================
// ctrl register field positions (low bit of each field)
`define AAM_CTRL_OPCLASS    0
`define AAM_CTRL_REQREP     2
`define AAM_CTRL_SENDER_IP_MODE 4
`define AAM_CTRL_TIP_MODE   6
`define AAM_CTRL_ARP_SRC_MAC 8
`define AAM_CTRL_RARP_SRC_MAC 10
`define AAM_CTRL_LEN        12
`define AAM_CTRL_HW_SPACE   14
`define AAM_CTRL_PROTO_SPC  16
`define AAM_CTRL_TYPE_SPEC  18
`define AAM_CTRL_CODE_SPEC  19
`define AAM_CTRL_KIND       20
`define AAM_CTRL_ENABLE     21
`define AAM_CTRL_WIDTH      22

// icmp register field positions
`define AAM_ICMP_TYPE       0
`define AAM_ICMP_CODE       8

// ==========================================================
// setting encodings
`define AAM_OPC_ANY         2'h0
`define AAM_OPC_ARP         2'h1
`define AAM_OPC_RARP        2'h2
`define AAM_OPC_OTHER       2'h3
`define AAM_RR_ANY          2'h0
`define AAM_RR_REQUEST      2'h1
`define AAM_RR_REPLY        2'h2
`define AAM_IP_ANY          2'h0
`define AAM_IP_HOST         2'h1
`define AAM_IP_NETWORK      2'h2
`define AAM_TRI_ZERO        2'h0
`define AAM_TRI_ONE         2'h1
`define AAM_TRI_ANY         2'h2

// ==========================================================
// header field values that the criteria test
`define AAM_OP_ARP_REQ      16'h0001
`define AAM_OP_ARP_REP      16'h0002
`define AAM_OP_RARP_REQ     16'h0003
`define AAM_OP_RARP_REP     16'h0004
`define AAM_HLEN_ETH        8'h06
`define AAM_PLEN_IPV4       8'h04
`define AAM_HW_SPACE_ETH    16'h0001
`define AAM_PROTO_IP        16'h0800

// ==========================================================
// reset values: every criterion at don't-care, entry disabled
`define AAM_RST_CTRL        22'h02aa00
`define AAM_RST_WORD        32'h00000000

`endif

/* hdl/aam_entry_matcher.v */
// one arp/rarp/icmp access control entry: apb config plus match logic
//
// Contract
// - opcode class any, arp, rarp or other; arp/rarp need their opcode kind.
// - other class matches only opcodes that are neither arp nor rarp.
// - request setting needs arp or rarp request; any accepts either.
// - reply setting needs arp reply or rarp reply opcode.
// - sender ip any, host or network; any ignores sender address.
// - sender host needs exact 32-bit equality with configured address.
// - sender network compares only where the sender mask is one.
// - target ip any, host or network; any ignores target address.
// - target host needs all 32 bits equal to configured target.
// - target network compares only where the target mask is one.
// - arp source mac check: 0 sender hw differs, 1 equal, any ignores.
// - rarp source mac check: 0 target hw differs, 1 equal, any ignores.
// - lengths 6/4 test: 0 excludes, 1 requires, any ignores.
// - hardware type equals 1 test: 0 rejects, 1 requires, any ignores.
// - protocol type equals 0x800: 0 rejects, 1 requires, any ignores.
// - icmp type any, or specific equal to configured type.
// - configured icmp type is eight bits, used when specific.
// - icmp code any, or specific equal to configured code.
// - configured icmp code is eight bits, used when specific.
`include "aam_defines.vh"
`default_nettype none

module aam_entry_matcher (
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // parsed header fields from the frame parser
  input wire frm_valid,
  input wire frm_is_arp,
  input wire frm_is_icmp,
  input wire [15:0] frm_opcode,
  input wire [15:0] hardware_space_field,
  input wire [15:0] frm_proto_type,
  input wire [7:0] frm_hw_len,
  input wire [7:0] frm_proto_len,
  input wire [47:0] frm_sender_hw,
  input wire [47:0] frm_target_hw,
  input wire [47:0] frame_source_mac,
  input wire [31:0] sender_ip,
  input wire [31:0] frm_target_ip,
  input wire [7:0] frm_icmp_type,
  input wire [7:0] frm_icmp_code,
  // result, one cycle after frm_valid
  output reg match_valid,
  output reg match_hit
);

  // ==========================================================
  // configuration registers
  reg [`AAM_CTRL_WIDTH-1:0] ctrl;
  reg [31:0] cfg_sender_ip;
  reg [31:0] cfg_sender_mask;
  reg [31:0] cfg_target_ip;
  reg [31:0] cfg_target_mask;
  reg [7:0] cfg_icmp_type;
  reg [7:0] cfg_icmp_code;
  reg [31:0] eval_cnt;
  reg [31:0] hit_cnt;

  wire [1:0] opclass = ctrl[`AAM_CTRL_OPCLASS +: 2];
  wire [1:0] reqrep = ctrl[`AAM_CTRL_REQREP +: 2];
  wire [1:0] sender_ip_mode = ctrl[`AAM_CTRL_SENDER_IP_MODE +: 2];
  wire [1:0] tip_mode = ctrl[`AAM_CTRL_TIP_MODE +: 2];
  wire [1:0] arp_src_mac_sel = ctrl[`AAM_CTRL_ARP_SRC_MAC +: 2];
  wire [1:0] rarp_src_mac_sel = ctrl[`AAM_CTRL_RARP_SRC_MAC +: 2];
  wire [1:0] len_sel = ctrl[`AAM_CTRL_LEN +: 2];
  wire [1:0] hw_space_sel = ctrl[`AAM_CTRL_HW_SPACE +: 2];
  wire [1:0] proto_space_sel = ctrl[`AAM_CTRL_PROTO_SPC +: 2];
  wire type_specific = ctrl[`AAM_CTRL_TYPE_SPEC];
  wire code_specific = ctrl[`AAM_CTRL_CODE_SPEC];
  wire kind_icmp = ctrl[`AAM_CTRL_KIND];
  wire entry_enable = ctrl[`AAM_CTRL_ENABLE];

  // ==========================================================
  // apb decode: zero wait states, data registered in the setup cycle
  wire setup_phase = psel & ~penable;
  wire wr_access = psel & penable & pwrite;
  reg addr_hit;
  reg [31:0] rd_word;

  always @* begin
    addr_hit = 1'b1;
    rd_word = 32'h00000000;
    case (paddr)
      `AAM_OFF_CTRL: rd_word = {{(32-`AAM_CTRL_WIDTH){1'b0}}, ctrl};
      `AAM_OFF_SENDER_IP: rd_word = cfg_sender_ip;
      `AAM_OFF_SENDER_MASK: rd_word = cfg_sender_mask;
      `AAM_OFF_TARGET_IP: rd_word = cfg_target_ip;
      `AAM_OFF_TARGET_MASK: rd_word = cfg_target_mask;
      `AAM_OFF_ICMP: rd_word = {16'h0000, cfg_icmp_code, cfg_icmp_type};
      `AAM_OFF_STATUS: rd_word = {30'h0000000, match_hit, match_valid};
      `AAM_OFF_EVAL_CNT: rd_word = eval_cnt;
      `AAM_OFF_HIT_CNT: rd_word = hit_cnt;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  // unmapped addresses answer with an error and write nothing
  assign pslverr = psel & penable & ~addr_hit;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `AAM_RST_WORD;
    end else if (setup_phase) begin
      prdata <= rd_word;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `AAM_RST_CTRL;
      cfg_sender_ip <= `AAM_RST_WORD;
      cfg_sender_mask <= `AAM_RST_WORD;
      cfg_target_ip <= `AAM_RST_WORD;
      cfg_target_mask <= `AAM_RST_WORD;
      cfg_icmp_type <= 8'h00;
      cfg_icmp_code <= 8'h00;
    end else if (wr_access) begin
      case (paddr)
        `AAM_OFF_CTRL: ctrl <= pwdata[`AAM_CTRL_WIDTH-1:0];
        `AAM_OFF_SENDER_IP: cfg_sender_ip <= pwdata;
        `AAM_OFF_SENDER_MASK: cfg_sender_mask <= pwdata;
        `AAM_OFF_TARGET_IP: cfg_target_ip <= pwdata;
        `AAM_OFF_TARGET_MASK: cfg_target_mask <= pwdata;
        `AAM_OFF_ICMP: begin
          // eight-bit fields hold the whole 0..255 range, nothing to clamp
          cfg_icmp_type <= pwdata[`AAM_ICMP_TYPE +: 8];
          cfg_icmp_code <= pwdata[`AAM_ICMP_CODE +: 8];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // criteria
  // three-way setting: zero needs the condition false, one needs it true,
  // any other value is don't-care
  function tri_ok;
    input [1:0] sel;
    input cond;
    begin
      case (sel)
        `AAM_TRI_ZERO: tri_ok = ~cond;
        `AAM_TRI_ONE: tri_ok = cond;
        default: tri_ok = 1'b1;
      endcase
    end
  endfunction

  // ip filter: host is an exact match, network only looks under the mask
  function ip_ok;
    input [1:0] mode;
    input [31:0] frame_ip;
    input [31:0] cfg_ip;
    input [31:0] cfg_mask;
    begin
      case (mode)
        `AAM_IP_HOST: ip_ok = (frame_ip == cfg_ip);
        `AAM_IP_NETWORK: ip_ok = (((frame_ip ^ cfg_ip) & cfg_mask) == 32'h00000000);
        default: ip_ok = 1'b1;
      endcase
    end
  endfunction

  wire op_arp_req = (frm_opcode == `AAM_OP_ARP_REQ);
  wire op_arp_rep = (frm_opcode == `AAM_OP_ARP_REP);
  wire op_rarp_req = (frm_opcode == `AAM_OP_RARP_REQ);
  wire op_rarp_rep = (frm_opcode == `AAM_OP_RARP_REP);
  wire op_is_arp = op_arp_req | op_arp_rep;
  wire op_is_rarp = op_rarp_req | op_rarp_rep;

  reg opclass_ok;
  always @* begin
    case (opclass)
      `AAM_OPC_ARP: opclass_ok = op_is_arp;
      `AAM_OPC_RARP: opclass_ok = op_is_rarp;
      `AAM_OPC_OTHER: opclass_ok = ~op_is_arp & ~op_is_rarp;
      default: opclass_ok = 1'b1;
    endcase
  end

  reg reqrep_ok;
  always @* begin
    case (reqrep)
      `AAM_RR_REQUEST: reqrep_ok = op_arp_req | op_rarp_req;
      `AAM_RR_REPLY: reqrep_ok = op_arp_rep | op_rarp_rep;
      default: reqrep_ok = 1'b1;
    endcase
  end

  wire sender_ip_ok = ip_ok(sender_ip_mode, sender_ip, cfg_sender_ip, cfg_sender_mask);
  wire tip_ok = ip_ok(tip_mode, frm_target_ip, cfg_target_ip, cfg_target_mask);

  // the source mac tests only bind frames of their own opcode kind
  wire arp_src_mac_ok = ~op_is_arp |
    tri_ok(arp_src_mac_sel, frm_sender_hw == frame_source_mac);
  wire rarp_src_mac_ok = ~op_is_rarp |
    tri_ok(rarp_src_mac_sel, frm_target_hw == frame_source_mac);
  wire len_ok = tri_ok(len_sel,
    (frm_hw_len == `AAM_HLEN_ETH) & (frm_proto_len == `AAM_PLEN_IPV4));
  wire hw_space_ok = tri_ok(hw_space_sel,
    hardware_space_field == `AAM_HW_SPACE_ETH);
  wire proto_space_ok = tri_ok(proto_space_sel,
    frm_proto_type == `AAM_PROTO_IP);

  wire type_ok = ~type_specific | (frm_icmp_type == cfg_icmp_type);
  wire code_ok = ~code_specific | (frm_icmp_code == cfg_icmp_code);

  wire arp_all_ok = frm_is_arp & opclass_ok & reqrep_ok & sender_ip_ok & tip_ok &
    arp_src_mac_ok & rarp_src_mac_ok & len_ok & hw_space_ok & proto_space_ok;
  wire icmp_all_ok = frm_is_icmp & type_ok & code_ok;
  wire next_hit = entry_enable & (kind_icmp ? icmp_all_ok : arp_all_ok);

  // ==========================================================
  // result and counters; fields are sampled only in the strobe cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_valid <= 1'b0;
      match_hit <= 1'b0;
      eval_cnt <= `AAM_RST_WORD;
      hit_cnt <= `AAM_RST_WORD;
    end else begin
      match_valid <= frm_valid;
      if (frm_valid) begin
        match_hit <= next_hit;
        eval_cnt <= eval_cnt + 32'h00000001;
        // counters wrap; software takes differences between reads
        if (next_hit) begin
          hit_cnt <= hit_cnt + 32'h00000001;
        end
      end else begin
        match_hit <= 1'b0;
      end
    end
  end

endmodule // aam_entry_matcher
`default_nettype wire

/* bench/aam_parser_model.sv */
// frame parser model: parsed header fields with a one-cycle strobe
`default_nettype none
module aam_parser_model (
  input wire logic req,
  input wire logic [289:0] fi,
  output logic frm_valid,
  output logic [289:0] fo
);
  timeunit 1ns;
  timeprecision 1ps;
  assign frm_valid = req;
  // fields only hold during the strobe; inverted otherwise so a stale sample shows up
  assign fo = req ? fi : ~fi;
endmodule // aam_parser_model
`default_nettype wire

/* bench/aam_entry_matcher_properties.sv */
// port assertions for the entry matcher
`default_nettype none
module aam_entry_matcher_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frm_valid,
  input wire logic frm_is_arp,
  input wire logic frm_is_icmp,
  input wire logic match_valid,
  input wire logic match_hit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lat; frm_valid |=> match_valid; endproperty
  a_lat: assert property (p_lat) else $error("no result");
  property p_spur; !frm_valid |=> !match_valid; endproperty
  a_spur: assert property (p_spur) else $error("stray result");
  property p_hv; match_hit |-> match_valid; endproperty
  a_hv: assert property (p_hv) else $error("hit alone");
  property p_cls; match_hit |-> $past(frm_is_arp || frm_is_icmp); endproperty
  a_cls: assert property (p_cls) else $error("hit on wrong class");
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err; psel && penable && paddr > 8'h20 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok; psel && penable && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("false error");
  property p_rz; psel && !penable && paddr > 8'h20 |=> prdata == 32'h0; endproperty
  a_rz: assert property (p_rz) else $error("data on hole");
endmodule // aam_entry_matcher_properties
bind aam_entry_matcher aam_entry_matcher_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .frm_valid(frm_valid), .frm_is_arp(frm_is_arp),
  .frm_is_icmp(frm_is_icmp), .match_valid(match_valid), .match_hit(match_hit));
`default_nettype wire

/* bench/aam_entry_matcher_bench.sv */
// self-checking bench for the arp/icmp entry matcher
`include "aam_defines.vh"
`default_nettype none
module aam_entry_matcher_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SND_IP = 32'hc0a80101;
  localparam logic [31:0] TIP = 32'hc0a801fe;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req = 1'b0;
  logic is_arp = 1'b1, is_icmp = 1'b0, e, fv, mv, mh, rdy, err, x;
  logic [7:0] paddr = 8'h00, hl = 8'h06, ity = 8'h00, ico = 8'hff;
  logic [15:0] op = 16'h0001, hwt = 16'h0001, pt = 16'h0800;
  logic [47:0] shw = 48'h0, thw = 48'h0, src_mac = 48'h0a0b0c0d0e0f;
  logic [31:0] pwdata = 32'h0, prdata, rd, d, snd_ip = SND_IP, tip = TIP;
  logic [289:0] fo;
  int num_errors = 0, checks_done = 0, i, j, k, probes = 0, hits = 0;
  always #2 pclk = ~pclk;
  aam_parser_model u_prs (.req(req), .fi({is_arp, is_icmp, op, hwt, pt, hl, 8'h04, shw, thw,
    src_mac, snd_ip, tip, ity, ico}), .frm_valid(fv), .fo(fo));
  aam_entry_matcher u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy),
    .pslverr(err), .frm_valid(fv), .frm_is_arp(fo[289]), .frm_is_icmp(fo[288]),
    .frm_opcode(fo[287:272]), .hardware_space_field(fo[271:256]),
    .frm_proto_type(fo[255:240]), .frm_hw_len(fo[239:232]), .frm_proto_len(fo[231:224]),
    .frm_sender_hw(fo[223:176]), .frm_target_hw(fo[175:128]),
    .frame_source_mac(fo[127:80]), .sender_ip(fo[79:48]), .frm_target_ip(fo[47:16]),
    .frm_icmp_type(fo[15:8]), .frm_icmp_code(fo[7:0]), .match_valid(mv), .match_hit(mh));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge pclk);
      if (rdy === 1'b1) break;
    end
    if (n == 64) begin
      num_errors++;
      close_out;
    end
    rd = prdata;
    e = err;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ctrl starts from all-don't-care with the entry enabled
  task automatic cfg(input int lo, input logic [1:0] v, input logic [31:0] m);
    logic [31:0] c;
    c = {10'h000, `AAM_RST_CTRL} | (32'h1 << `AAM_CTRL_ENABLE) | m;
    c[lo +: 2] = v;
    apb(1'b1, `AAM_OFF_CTRL, c);
  endtask
  task automatic probe(input logic h);
    probes++;
    hits += h;
    @(posedge pclk);
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
    #1;
    chk(mv, 1'b1);
    chk(mh, h);
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `AAM_OFF_CTRL, 32'h0);
    chk(rd, {10'h000, `AAM_RST_CTRL});
    apb(1'b1, 8'h24, 32'hffffffff);
    chk(e, 1'b1);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `AAM_OFF_SENDER_IP, SND_IP);
    apb(1'b1, `AAM_OFF_SENDER_MASK, 32'hffffff00);
    apb(1'b1, `AAM_OFF_TARGET_IP, TIP);
    apb(1'b1, `AAM_OFF_TARGET_MASK, 32'hffffff00);
    apb(1'b1, `AAM_OFF_ICMP, 32'h0000ff00);
    probe(1'b0);
    $display("register tests done");
    for (i = 0; i < 4; i++) begin
      cfg(`AAM_CTRL_OPCLASS, i[1:0], 32'h0);
      for (j = 1; j < 6; j++) begin
        op <= j[15:0];
        x = i == 0 || (i == 1 && j < 3) || (i == 2 && j inside {3, 4}) || (i == 3 && j == 5);
        probe(x);
      end
    end
    for (i = 0; i < 4; i++) begin
      cfg(`AAM_CTRL_REQREP, i[1:0], 32'h0);
      for (j = 1; j < 5; j++) begin
        op <= j[15:0];
        probe(i == 0 || i == 3 || (i == 1) == j[0]);
      end
    end
    $display("opcode tests done");
    for (k = 0; k < 2; k++)
      for (i = 0; i < 4; i++) begin
        cfg(`AAM_CTRL_SENDER_IP_MODE + 2 * k, i[1:0], 32'h0);
        for (j = 0; j < 3; j++) begin
          d = (j == 2) ? 32'h00000100 : j;
          snd_ip <= SND_IP ^ ((k == 0) ? d : 32'h0);
          tip <= TIP ^ ((k == 1) ? d : 32'h0);
          x = i == 0 || i == 3 || (i == 1 && j == 0) || (i == 2 && j != 2);
          probe(x);
        end
      end
    $display("address tests done");
    for (k = 0; k < 5; k++)
      for (i = 0; i < 4; i++) begin
        cfg(`AAM_CTRL_ARP_SRC_MAC + 2 * k, i[1:0], 32'h0);
        for (j = 0; j < 2; j++) begin
          op <= (k == 1) ? 16'h0003 : 16'h0001;
          shw <= (k == 0 && j == 0) ? 48'h1 : src_mac;
          thw <= (k == 1 && j == 0) ? 48'h1 : src_mac;
          hl <= (k == 2 && j == 0) ? 8'h07 : 8'h06;
          hwt <= (k == 3 && j == 0) ? 16'h0006 : 16'h0001;
          pt <= (k == 4 && j == 0) ? 16'h0806 : 16'h0800;
          probe(i >= 2 || (i == 1) == (j == 1));
        end
      end
    $display("three-way tests done");
    is_arp <= 1'b0;
    is_icmp <= 1'b1;
    for (i = 0; i < 4; i++) begin
      cfg(`AAM_CTRL_TYPE_SPEC, i[1:0], 32'h1 << `AAM_CTRL_KIND);
      for (j = 0; j < 3; j++) begin
        ity <= (j == 1) ? 8'h01 : 8'h00;
        ico <= (j == 2) ? 8'hfe : 8'hff;
        probe(!(i[0] && j == 1) && !(i[1] && j == 2));
      end
    end
    cfg(`AAM_CTRL_TYPE_SPEC, 2'h0, 32'h1 << `AAM_CTRL_KIND);
    is_icmp <= 1'b0;
    probe(1'b0);
    is_icmp <= 1'b1;
    probe(1'b1);
    cfg(`AAM_CTRL_OPCLASS, 2'h0, 32'h0);
    probe(1'b0);
    $display("icmp tests done");
    apb(1'b0, `AAM_OFF_EVAL_CNT, 32'h0);
    chk(rd, probes);
    apb(1'b0, `AAM_OFF_HIT_CNT, 32'h0);
    chk(rd, hits);
    $display("counter tests done");
    close_out;
  end
endmodule // aam_entry_matcher_bench
`default_nettype wire
